//--- pkg/btcs_defines.svh
/*
  Constants of the base torque command shaper: timing, register offsets,
  field positions, reset values and calibration table layout.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef BTCS_DEFINES_SVH
`define BTCS_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BTCS_CLK_NS 4
`define BTCS_LOOP_MS 1
`define BTCS_LOOP_CYC (`BTCS_LOOP_MS * 1000000 / `BTCS_CLK_NS)
`define BTCS_FRAC 10
`define BTCS_STEP_SCALE (`BTCS_LOOP_MS * 1048576 / 1000)

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BTCS_CTRL_OFF 12'h000
`define BTCS_CREEP_OFF 12'h004
`define BTCS_CSPD_OFF 12'h008
`define BTCS_REGEN_OFF 12'h00c
`define BTCS_RZERO_OFF 12'h010
`define BTCS_OPED_OFF 12'h014
`define BTCS_OTIME_OFF 12'h018
`define BTCS_STAT_OFF 12'h01c
`define BTCS_ELAP_OFF 12'h020
`define BTCS_TBL_SEL 2'h1

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define BTCS_CREEP_EN_BIT 0
`define BTCS_REGEN_EN_BIT 1
`define BTCS_AXIS_SEL_BIT 2
`define BTCS_NEED_BRK_BIT 3
`define BTCS_OVR_EN_BIT 4
`define BTCS_CTRL_W 5

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define BTCS_ST_OVR_BIT 16
`define BTCS_ST_CREEP_BIT 17
`define BTCS_ST_REGEN_BIT 18
`define BTCS_ST_ARM_BIT 19
`define BTCS_ST_LVL_LSB 20

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BTCS_CTRL_RST 5'h00
`define BTCS_HALF_RST 16'h0000
`define BTCS_OTIME_RST 16'h0064
`define BTCS_UNITY 16'h0100

// ----------------------------------------------------------------------
// Table layout (entry indices)
// ----------------------------------------------------------------------
`define BTCS_TMAP_BASE 8'd0
`define BTCS_TRIM_BASE 8'd16
`define BTCS_PED_BASE 8'd32
`define BTCS_CREEP_BASE 8'd96
`define BTCS_REV_BASE 8'd100
`define BTCS_RGN_BASE 8'd104
`define BTCS_LRISE_BASE 8'd120
`define BTCS_LFALL_BASE 8'd140
`define BTCS_CRISE_BASE 8'd160
`define BTCS_CFALL_BASE 8'd165
`define BTCS_TBL_DEPTH 170

`endif

//--- pkg/btcs_pkg.sv
/*
  Types shared by the torque command shaper.
  Assumes the defines header sits beside it.
*/
`include "btcs_defines.svh"

package btcs_pkg;

  typedef logic signed [15:0] btcs_torque_t;

  typedef enum logic [4:0] {
    BTCS_BASE  = 5'b00001,
    BTCS_REGEN = 5'b00010,
    BTCS_CREEP = 5'b00100,
    BTCS_REV   = 5'b01000,
    BTCS_OVR   = 5'b10000
  } btcs_mode_t;

endpackage : btcs_pkg

//--- verilog/btcs_bin.sv
/*
  Axis breakpoint finder: splits an unsigned input range evenly into
  BINS cells and returns the cell index.
  Assumes IW bits can hold BINS-1; purely combinational.
*/
`timescale 1ns/1ps

module btcs_bin #(
  parameter int W = 16,
  parameter int BINS = 4,
  parameter int IW = 2
) (
  input wire logic [W-1:0] value_in,
  output logic [IW-1:0] index_out
);

  logic [W+IW-1:0] prod;

  // Multiply-and-take-top avoids a divider and never exceeds BINS-1
  assign prod = value_in * (W+IW)'(BINS);
  assign index_out = prod[W+IW-1:W];

endmodule : btcs_bin

//--- verilog/btcs_shaper.sv
/*
  Base torque command shaper: APB calibration store, table lookups,
  creep / reverse / regen overrides, brake-throttle override and
  per-loop slew limiting of the signed torque command.
  Assumes sensor inputs come from logic on clk_in, except the brake
  switch pin, and that an APB master drives the register port.
*/
// The APB interface to the registers and the register offsets were decided locally.
// What this block does
// R1 - Base command is formed first; caps and derates come later, outside.
// R2 - Raw target from speed by bus voltage map, in newton-metres.
// R3 - Speed-indexed trim multiplies request; 1.00 keeps it, 0.50 halves.
// R4 - Pedal multiplier map by speed and pedal; negative entries regenerate.
// R5 - Four pedal maps; the active performance level picks one.
// R6 - Creep only when enabled and pedal at or below limit; replaces base.
// R7 - Creep speed hysteresis: off above first, on below second threshold.
// R8 - Reverse replaces base with pedal-indexed reverse torque.
// R9 - Regen map needs enable, speed, low pedal, optional brake switch.
// R10 - Regen map indexed by speed and selected pressure or lever axis.
// R11 - Regen forced zero below low speed, allowed again above high speed.
// R12 - Override arms above upper pedal, disarms below lower, if enabled.
// R13 - Millisecond timer of pedal high with brake; latch at limit.
// R14 - Latched override forces outgoing torque to zero.
// R15 - Rise and fall slew tables by vehicle speed for each of four levels.
// R16 - Level selection always applies, even with no keypad present.
// R17 - Creep or reverse use one shared rise and fall slew pair.
// R18 - Command is signed: motoring positive, generating negative.
// R19 - Each loop moves command at most slew rate times loop period.
`timescale 1ns/1ps
`include "btcs_defines.svh"

module btcs_shaper #(
  parameter int unsigned LOOP_CYCLES = `BTCS_LOOP_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [15:0] motor_speed_in,
  input wire logic [15:0] bus_voltage_in,
  input wire logic [15:0] pedal_in,
  input wire logic [15:0] vehicle_speed_in,
  input wire logic [15:0] brake_pressure_in,
  input wire logic [15:0] regen_lever_in,
  input wire logic brake_switch_in,
  input wire logic reverse_in,
  input wire logic [1:0] level_in,
  input wire logic level_valid_in,
  output btcs_pkg::btcs_torque_t torque_cmd_out,
  output logic cmd_valid_out,
  output logic override_out,
  output logic creep_out,
  output logic regen_out
);
  import btcs_pkg::*;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [`BTCS_CTRL_W-1:0] ctrl_reg;
  logic [15:0] creep_pedal_limit_reg;
  logic [15:0] creep_off_reg;
  logic [15:0] creep_on_reg;
  logic [15:0] regen_pedal_limit_reg;
  logic [15:0] regen_min_speed_reg;
  logic [15:0] regen_zero_lo_reg;
  logic [15:0] regen_zero_hi_reg;
  logic [15:0] ovr_on_reg;
  logic [15:0] ovr_off_reg;
  logic [15:0] override_time_limit_reg;
  logic [15:0] tbl_reg [0:`BTCS_TBL_DEPTH-1];
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic brk_meta_reg;
  logic brk_sync_reg;
  logic [1:0] level_reg;
  logic [23:0] loop_cnt_reg;
  logic creep_spd_ok_reg;
  logic regen_spd_ok_reg;
  logic ovr_armed_reg;
  logic [15:0] override_elapsed_ms_reg;
  logic override_latched_reg;
  logic signed [26:0] acc_reg;
  btcs_torque_t torque_reg;
  logic valid_reg;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic setup_ph;
  logic wr_acc;
  logic tbl_sel;
  logic [7:0] tbl_idx;
  logic tbl_ok;
  logic [31:0] rd_mux;
  logic rd_err;
  logic wr_err;

  assign setup_ph = psel_in && !penable_in;
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign tbl_sel = (paddr_in[11:10] == `BTCS_TBL_SEL);
  assign tbl_idx = paddr_in[9:2];
  assign tbl_ok = tbl_sel && (tbl_idx < 8'(`BTCS_TBL_DEPTH));

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    wr_err = 1'b0;
    if (tbl_sel) begin
      rd_mux = {16'h0000, tbl_ok ? tbl_reg[tbl_idx] : 16'h0000};
      rd_err = !tbl_ok;
      wr_err = !tbl_ok;
    end else begin
      case (paddr_in)
        `BTCS_CTRL_OFF: rd_mux = {27'h0, ctrl_reg};
        `BTCS_CREEP_OFF: rd_mux = {16'h0000, creep_pedal_limit_reg};
        `BTCS_CSPD_OFF: rd_mux = {creep_on_reg, creep_off_reg};
        `BTCS_REGEN_OFF: rd_mux = {regen_min_speed_reg,
                                  regen_pedal_limit_reg};
        `BTCS_RZERO_OFF: rd_mux = {regen_zero_hi_reg, regen_zero_lo_reg};
        `BTCS_OPED_OFF: rd_mux = {ovr_off_reg, ovr_on_reg};
        `BTCS_OTIME_OFF: rd_mux = {16'h0000, override_time_limit_reg};
        `BTCS_STAT_OFF: begin
          rd_mux[15:0] = torque_reg;
          rd_mux[`BTCS_ST_OVR_BIT] = override_latched_reg;
          rd_mux[`BTCS_ST_CREEP_BIT] = creep_out;
          rd_mux[`BTCS_ST_REGEN_BIT] = regen_out;
          rd_mux[`BTCS_ST_ARM_BIT] = ovr_armed_reg;
          rd_mux[`BTCS_ST_LVL_LSB +: 2] = level_reg;
          wr_err = 1'b1;
        end
        `BTCS_ELAP_OFF: begin
          rd_mux = {16'h0000, override_elapsed_ms_reg};
          wr_err = 1'b1;
        end
        default: begin
          rd_err = 1'b1;
          wr_err = 1'b1;
        end
      endcase
    end
  end

  // Answer is prepared in the setup cycle so data leaves a flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= pwrite_in ? wr_err : rd_err;
    end
  end

  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg;
  assign pready_out = 1'b1;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_reg <= `BTCS_CTRL_RST;
      creep_pedal_limit_reg <= `BTCS_HALF_RST;
      creep_off_reg <= `BTCS_HALF_RST;
      creep_on_reg <= `BTCS_HALF_RST;
      regen_pedal_limit_reg <= `BTCS_HALF_RST;
      regen_min_speed_reg <= `BTCS_HALF_RST;
      regen_zero_lo_reg <= `BTCS_HALF_RST;
      regen_zero_hi_reg <= `BTCS_HALF_RST;
      ovr_on_reg <= `BTCS_HALF_RST;
      ovr_off_reg <= `BTCS_HALF_RST;
      override_time_limit_reg <= `BTCS_OTIME_RST;
    end else if (wr_acc && !tbl_sel) begin
      case (paddr_in)
        `BTCS_CTRL_OFF: ctrl_reg <= pwdata_in[`BTCS_CTRL_W-1:0];
        `BTCS_CREEP_OFF: creep_pedal_limit_reg <= pwdata_in[15:0];
        `BTCS_CSPD_OFF: begin
          creep_off_reg <= pwdata_in[15:0];
          creep_on_reg <= pwdata_in[31:16];
        end
        `BTCS_REGEN_OFF: begin
          regen_pedal_limit_reg <= pwdata_in[15:0];
          regen_min_speed_reg <= pwdata_in[31:16];
        end
        `BTCS_RZERO_OFF: begin
          regen_zero_lo_reg <= pwdata_in[15:0];
          regen_zero_hi_reg <= pwdata_in[31:16];
        end
        `BTCS_OPED_OFF: begin
          ovr_on_reg <= pwdata_in[15:0];
          ovr_off_reg <= pwdata_in[31:16];
        end
        `BTCS_OTIME_OFF: override_time_limit_reg <= pwdata_in[15:0];
        default: ;
      endcase
    end
  end

  // Tables power up empty (zero torque) and stay so until calibrated
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < `BTCS_TBL_DEPTH; i++) begin
        tbl_reg[i] <= 16'h0000;
      end
    end else if (wr_acc && tbl_ok) begin
      tbl_reg[tbl_idx] <= pwdata_in[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Inputs, level and loop tick
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      brk_meta_reg <= 1'b0;
      brk_sync_reg <= 1'b0;
    end else begin
      brk_meta_reg <= brake_switch_in;
      brk_sync_reg <= brk_meta_reg;
    end
  end

  // R16 level always held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_reg <= 2'h0;
    end else if (level_valid_in) begin
      level_reg <= level_in;
    end
  end

  logic tick;
  assign tick = (loop_cnt_reg == 24'(LOOP_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || tick) begin
      loop_cnt_reg <= 24'h00_0000;
    end else begin
      loop_cnt_reg <= loop_cnt_reg + 24'h00_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Axis bins
  // ----------------------------------------------------------------------
  logic [15:0] axis_val [0:4];
  logic [1:0] axis_bin [0:4];
  logic [2:0] vspd_bin5;
  logic [15:0] regen_y;

  // R10 selectable regen axis
  assign regen_y = ctrl_reg[`BTCS_AXIS_SEL_BIT] ? regen_lever_in
                                                : brake_pressure_in;
  assign axis_val[0] = motor_speed_in;
  assign axis_val[1] = bus_voltage_in;
  assign axis_val[2] = pedal_in;
  assign axis_val[3] = vehicle_speed_in;
  assign axis_val[4] = regen_y;

  for (genvar g = 0; g < 5; g++) begin : g_axis
    btcs_bin #(.W(16), .BINS(4), .IW(2)) u_bin (
      .value_in(axis_val[g]),
      .index_out(axis_bin[g])
    );
  end

  btcs_bin #(.W(16), .BINS(5), .IW(3)) u_bin5 (
    .value_in(vehicle_speed_in),
    .index_out(vspd_bin5)
  );

  // ----------------------------------------------------------------------
  // Base command
  // ----------------------------------------------------------------------
  btcs_torque_t raw_torque_target;
  btcs_torque_t speed_trim;
  btcs_torque_t final_pedal_multiplier;
  logic signed [31:0] trim_prod;
  logic signed [31:0] ped_prod;
  btcs_torque_t trimmed;
  btcs_torque_t base_cmd;

  // R2 speed by voltage map
  assign raw_torque_target =
    tbl_reg[`BTCS_TMAP_BASE + {4'h0, axis_bin[0], axis_bin[1]}];
  // R3 trim, unity 0x0100
  assign speed_trim = tbl_reg[`BTCS_TRIM_BASE + {6'h00, axis_bin[0]}];
  assign trim_prod = raw_torque_target * speed_trim;
  assign trimmed = trim_prod[23:8];
  // R5 level picks map
  assign final_pedal_multiplier = tbl_reg[`BTCS_PED_BASE +
    {2'h0, level_reg, axis_bin[0], axis_bin[2]}];
  // R4 signed pedal scaling
  assign ped_prod = trimmed * final_pedal_multiplier;
  // R1 base formed before any cap
  assign base_cmd = ped_prod[23:8];

  // ----------------------------------------------------------------------
  // Hysteresis flags
  // ----------------------------------------------------------------------
  // R7 creep speed window
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      creep_spd_ok_reg <= 1'b0;
    end else if (vehicle_speed_in > creep_off_reg) begin
      creep_spd_ok_reg <= 1'b0;
    end else if (vehicle_speed_in < creep_on_reg) begin
      creep_spd_ok_reg <= 1'b1;
    end
  end

  // R11 regen zero-speed window
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      regen_spd_ok_reg <= 1'b0;
    end else if (motor_speed_in < regen_zero_lo_reg) begin
      regen_spd_ok_reg <= 1'b0;
    end else if (motor_speed_in > regen_zero_hi_reg) begin
      regen_spd_ok_reg <= 1'b1;
    end
  end

  // R12 override arming
  always_ff @(posedge clk_in) begin
    if (rst_in || !ctrl_reg[`BTCS_OVR_EN_BIT]) begin
      ovr_armed_reg <= 1'b0;
    end else if (pedal_in > ovr_on_reg) begin
      ovr_armed_reg <= 1'b1;
    end else if (pedal_in < ovr_off_reg) begin
      ovr_armed_reg <= 1'b0;
    end
  end

  // R13 pedal-high timer with brake
  always_ff @(posedge clk_in) begin
    if (rst_in || !(ovr_armed_reg && brk_sync_reg)) begin
      override_elapsed_ms_reg <= 16'h0000;
    end else if (tick && override_elapsed_ms_reg != 16'hffff) begin
      override_elapsed_ms_reg <=
        override_elapsed_ms_reg + 16'(`BTCS_LOOP_MS);
    end
  end

  // R13 latch at limit; released once disarmed
  always_ff @(posedge clk_in) begin
    if (rst_in || !ovr_armed_reg) begin
      override_latched_reg <= 1'b0;
    end else if (brk_sync_reg &&
                 override_elapsed_ms_reg >= override_time_limit_reg) begin
      override_latched_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Mode and target
  // ----------------------------------------------------------------------
  logic creep_act;
  logic regen_act;
  btcs_mode_t mode;
  btcs_torque_t target;
  btcs_torque_t regen_tq;

  // R6 creep gate
  assign creep_act = ctrl_reg[`BTCS_CREEP_EN_BIT] && creep_spd_ok_reg &&
                     (pedal_in <= creep_pedal_limit_reg) && !reverse_in;
  // R9 four regen conditions
  assign regen_act = ctrl_reg[`BTCS_REGEN_EN_BIT] &&
                     (vehicle_speed_in > regen_min_speed_reg) &&
                     (pedal_in < regen_pedal_limit_reg) &&
                     (!ctrl_reg[`BTCS_NEED_BRK_BIT] || brk_sync_reg);
  // R11 regen held at zero
  assign regen_tq = regen_spd_ok_reg ?
    tbl_reg[`BTCS_RGN_BASE + {4'h0, axis_bin[0], axis_bin[4]}] : '0;

  always_comb begin
    if (override_latched_reg) begin
      mode = BTCS_OVR;
    end else if (reverse_in) begin
      mode = BTCS_REV;
    end else if (creep_act) begin
      mode = BTCS_CREEP;
    end else if (regen_act) begin
      mode = BTCS_REGEN;
    end else begin
      mode = BTCS_BASE;
    end
  end

  // R18 signed target; R8 reverse; R6 creep replaces base
  always_comb begin
    case (mode)
      BTCS_OVR: target = '0;
      BTCS_REV: target =
        tbl_reg[`BTCS_REV_BASE + {6'h00, axis_bin[2]}];
      BTCS_CREEP: target =
        tbl_reg[`BTCS_CREEP_BASE + {6'h00, axis_bin[3]}];
      BTCS_REGEN: target = regen_tq;
      BTCS_BASE: target = base_cmd;
      default: target = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Slew limiting
  // ----------------------------------------------------------------------
  logic rc_mode;
  logic [7:0] rise_idx;
  logic [7:0] fall_idx;
  logic [15:0] rate;
  logic [26:0] step_prod;
  logic signed [26:0] step_s;
  logic signed [26:0] target_q;
  logic signed [26:0] diff;
  logic signed [26:0] acc_next;

  assign rc_mode = (mode == BTCS_REV) || (mode == BTCS_CREEP);
  // R17 shared pair; R15 per-level pair
  assign rise_idx = rc_mode ? `BTCS_CRISE_BASE + {5'h00, vspd_bin5} :
    `BTCS_LRISE_BASE + {6'h00, level_reg} * 8'd5 + {5'h00, vspd_bin5};
  assign fall_idx = rc_mode ? `BTCS_CFALL_BASE + {5'h00, vspd_bin5} :
    `BTCS_LFALL_BASE + {6'h00, level_reg} * 8'd5 + {5'h00, vspd_bin5};

  assign target_q = {target[15], target, `BTCS_FRAC'(0)};
  assign diff = target_q - acc_reg;
  assign rate = (diff > 0) ? tbl_reg[rise_idx] : tbl_reg[fall_idx];
  // Nm/s scaled to one loop period; full-scale rate needs all 27 bits
  assign step_prod = rate * 27'(`BTCS_STEP_SCALE);
  assign step_s = 27'(step_prod[26:`BTCS_FRAC]);

  // R19 bounded step toward target
  always_comb begin
    if (diff > step_s) begin
      acc_next = acc_reg + step_s;
    end else if (diff < -step_s) begin
      acc_next = acc_reg - step_s;
    end else begin
      acc_next = target_q;
    end
  end

  // R14 latched override forces zero at the next loop tick
  always_ff @(posedge clk_in) begin
    if (rst_in || (tick && override_latched_reg)) begin
      acc_reg <= '0;
      torque_reg <= '0;
    end else if (tick) begin
      acc_reg <= acc_next;
      torque_reg <= acc_next[25:`BTCS_FRAC];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= tick;
    end
  end

  assign torque_cmd_out = torque_reg;
  assign cmd_valid_out = valid_reg;
  assign override_out = override_latched_reg;
  assign creep_out = (mode == BTCS_CREEP);
  assign regen_out = (mode == BTCS_REGEN);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_apb_setup;
    psel_in && !penable_in;
  endsequence

  sequence s_armed_brake;
    ovr_armed_reg && brk_sync_reg;
  endsequence

  apb_answer_a: assert property ( // APB, decided locally
    s_apb_setup ##1 (psel_in && penable_in) |-> pready_out
  ) else $error("APB access not answered in zero waits");

  level_hold_a: assert property ( // R16
    !level_valid_in |=> level_reg == $past(level_reg)
  ) else $error("Performance level changed without selection");

  creep_hyst_a: assert property ( // R7
    (vehicle_speed_in > creep_off_reg) |=> !creep_spd_ok_reg ##0 !creep_out
  ) else $error("Creep still allowed above off speed");

  creep_gate_a: assert property ( // R6
    creep_out |-> ctrl_reg[`BTCS_CREEP_EN_BIT] &&
                  pedal_in <= creep_pedal_limit_reg
  ) else $error("Creep active outside its gate");

  regen_zero_a: assert property ( // R11
    (motor_speed_in < regen_zero_lo_reg) |=> regen_tq == 16'h0000
  ) else $error("Regen torque not zero below low speed");

  regen_gate_a: assert property ( // R9
    regen_out |-> vehicle_speed_in > regen_min_speed_reg &&
                  pedal_in < regen_pedal_limit_reg &&
                  ctrl_reg[`BTCS_REGEN_EN_BIT]
  ) else $error("Regen map used outside activation criteria");

  arm_hyst_a: assert property ( // R12
    (ctrl_reg[`BTCS_OVR_EN_BIT] && pedal_in > ovr_on_reg)
      |=> ovr_armed_reg
  ) else $error("Override failed to arm above upper threshold");

  ovr_latch_a: assert property ( // R13
    (s_armed_brake ##0 override_elapsed_ms_reg >= override_time_limit_reg)
      |=> override_latched_reg || !ovr_armed_reg
  ) else $error("Override did not latch at time limit");

  ovr_zero_a: assert property ( // R14
    (tick && override_latched_reg) |=> torque_reg == 16'h0000 [*2]
  ) else $error("Torque not zero under override");

  slew_bound_a: assert property ( // R19
    (tick && !override_latched_reg) |=>
      (acc_reg - $past(acc_reg) <= $past(step_s)) &&
      ($past(acc_reg) - acc_reg <= $past(step_s))
  ) else $error("Command moved more than one slew step");

endmodule : btcs_shaper

//--- testbench/btcs_inv_model.sv
/*
  Inverter stand-in: keeps the last torque request handed to it.
  Assumes the request pulse and value share the shaper's clock.
*/
`timescale 1ns/1ps

module btcs_inv_model (
  input wire logic clk_in,
  input wire logic valid_in,
  input wire btcs_pkg::btcs_torque_t torque_in,
  output btcs_pkg::btcs_torque_t last_out
);
  import btcs_pkg::*;
  always_ff @(posedge clk_in) begin
    if (valid_in) begin
      last_out <= torque_in;
    end
  end
endmodule : btcs_inv_model

//--- testbench/testbench.sv
/*
  Directed bench of the torque command shaper over APB.
  Assumes a 20-cycle loop so each 200-cycle wait spans ten loop ticks.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module testbench;
  import btcs_pkg::*;
  logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, rd, prdata_out;
  logic [15:0] motor_speed_in = 0, bus_voltage_in = 0, pedal_in = 0;
  logic [15:0] vehicle_speed_in = 0, brake_pressure_in = 0;
  logic [15:0] regen_lever_in = 0;
  logic [1:0] level_in = 0;
  logic brake_switch_in = 0, reverse_in = 0, level_valid_in = 0, err;
  logic pready_out, pslverr_out, cmd_valid_out, override_out;
  logic creep_out, regen_out;
  btcs_torque_t torque_cmd_out, seen;
  int errors = 0, n_tests = 0;

  initial forever #2 clk_in = ~clk_in;

  btcs_shaper #(.LOOP_CYCLES(20)) dut_u (.clk_in, .rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .motor_speed_in, .bus_voltage_in,
    .pedal_in, .vehicle_speed_in, .brake_pressure_in, .regen_lever_in,
    .brake_switch_in, .reverse_in, .level_in, .level_valid_in,
    .torque_cmd_out, .cmd_valid_out, .override_out, .creep_out,
    .regen_out);

  btcs_inv_model inv_u (.clk_in, .valid_in(cmd_valid_out),
    .torque_in(torque_cmd_out), .last_out(seen));

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    penable_in <= 0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask : apb

  task automatic tbl(input int i, input logic [15:0] v);
    apb(1, 12'h400 + 12'(4 * i), {16'h0, v});
  endtask : tbl

  // Ten loop ticks: enough for a full-rate slew to land
  task automatic loops();
    repeat (200) @(posedge clk_in);
  endtask : loops

  task automatic print_verdict();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (30000) @(posedge clk_in);
    errors++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 0;
    apb(0, 12'h018, 0);
    `CHK("time limit", 32'h64, rd)
    apb(0, 12'h7fc, 0);
    `CHK("unmapped", 1'b1, err)
    tbl(0, 16'd100);
    tbl(16, 16'h0100);
    tbl(32, 16'h0100);
    tbl(120, 16'hffff);
    tbl(140, 16'hffff);
    loops();
    `CHK("base", 16'sd100, seen)
    tbl(16, 16'h0080);
    loops();
    `CHK("half trim", 16'sd50, seen)
    tbl(48, 16'h0200);
    tbl(125, 16'hffff);
    tbl(145, 16'hffff);
    level_in <= 1;
    level_valid_in <= 1;
    @(posedge clk_in);
    level_valid_in <= 0;
    loops();
    `CHK("level two", 16'sd100, seen)
    apb(0, 12'h01c, 0);
    `CHK("level field", 2'h1, rd[21:20])
    tbl(48, 16'hff00);
    loops();
    `CHK("negative map", -16'sd50, seen)
    tbl(100, 16'hffec);
    tbl(165, 16'hffff);
    reverse_in <= 1;
    loops();
    `CHK("shared rise 0", -16'sd50, seen)
    tbl(160, 16'hffff);
    loops();
    `CHK("reverse", -16'sd20, seen)
    reverse_in <= 0;
    tbl(96, 16'd30);
    apb(1, 12'h008, 32'h0100_2000);
    apb(1, 12'h000, 32'h1);
    loops();
    `CHK("creep flag", 1'b1, creep_out)
    `CHK("creep", 16'sd30, seen)
    pedal_in <= 16'h0100;
    loops();
    `CHK("creep off", 1'b0, creep_out)
    pedal_in <= 16'h0;
    vehicle_speed_in <= 16'h3000;
    @(posedge clk_in);
    vehicle_speed_in <= 16'h1000;
    loops();
    `CHK("creep hyst", 1'b0, creep_out)
    tbl(51, 16'h0100);
    apb(1, 12'h014, 32'h1000_8000);
    apb(1, 12'h018, 32'h2);
    apb(1, 12'h000, 32'h10);
    pedal_in <= 16'hf000;
    brake_switch_in <= 1;
    loops();
    `CHK("latched", 1'b1, override_out)
    `CHK("zeroed", 16'sd0, seen)
    pedal_in <= 16'h0;
    loops();
    `CHK("released", 1'b0, override_out)
    `CHK("resumed", -16'sd50, seen)
    vehicle_speed_in <= 16'h0100;
    motor_speed_in <= 16'h0300;
    regen_lever_in <= 16'hc000;
    tbl(104, 16'hffd8);
    tbl(107, 16'hffc4);
    apb(1, 12'h00c, 32'h0010_0100);
    apb(1, 12'h010, 32'h0200_0100);
    apb(1, 12'h000, 32'h2);
    loops();
    `CHK("regen flag", 1'b1, regen_out)
    `CHK("regen map", -16'sd40, seen)
    apb(1, 12'h000, 32'h6);
    loops();
    `CHK("lever axis", -16'sd60, seen)
    motor_speed_in <= 16'h0080;
    loops();
    `CHK("regen zeroed", 16'sd0, seen)
    brake_switch_in <= 0;
    // About 10 Nm per 1 ms loop
    tbl(125, 16'd10006);
    apb(1, 12'h000, 32'ha);
    loops();
    `CHK("regen gated", 1'b0, regen_out)
    `CHK("back to base", -16'sd50, seen)
    @(posedge cmd_valid_out);
    @(posedge clk_in);
    pedal_in <= 16'hf000;
    @(posedge cmd_valid_out);
    @(posedge clk_in);
    `CHK("one step", -16'sd40, torque_cmd_out)
    print_verdict();
  end
endmodule : testbench
